//--- pkg/lalm_pkg.sv
/*
 lane alignment link monitor: register map, field positions, reset values,
 thresholds and the lane synchronisation state type.
 assumes a 16-bit management register port on the monitor's own clock.
*/
package lalm_pkg;
  // register offsets
  localparam logic [4:0] ADDR_CFG = 5'h0C;
  localparam logic [4:0] ADDR_TMR = 5'h0D;
  // reset values and writable bits (bit 3 has no function, reads zero)
  localparam logic [15:0] CFG_RST = 16'h03F0;
  localparam logic [15:0] CFG_WMASK = 16'hFFF7;
  localparam logic [15:0] TMR_RST = 16'hFFFF;
  // lane_align_config field positions
  localparam int CFG_THR_LSB = 0;
  localparam int CFG_REALIGN = 2;
  localparam int CFG_PLL_MASK = 4;
  localparam int CFG_LOS_MASK = 5;
  localparam int CFG_DEC_MASK = 7;
  localparam int CFG_SPACE_LSB = 8;
  localparam int CFG_HYS_LSB = 10;
  localparam int CFG_LSEL_LSB = 12;
  // error-rate thresholds, link good when count is below
  localparam logic [9:0] THR_0 = 10'h001;
  localparam logic [9:0] THR_1 = 10'h00F;
  localparam logic [9:0] THR_2 = 10'h07F;
  localparam logic [9:0] THR_3 = 10'h3FF;
  localparam logic [9:0] ERR_CNT_MAX = 10'h3FF;
  // least spacing between alignment characters
  localparam logic [4:0] SPACE_8 = 5'h08;
  localparam logic [4:0] SPACE_16 = 5'h10;
  localparam logic [4:0] SPACE_24 = 5'h18;
  // synchronisation counts
  localparam logic [1:0] ACQ_ALIGNS = 2'h3;
  localparam logic [1:0] GOOD_RUN = 2'h3;
  localparam logic [1:0] ERR_LVL_MAX = 2'h3;
  localparam int NUM_LANES = 4;

  typedef enum logic [1:0] {LALM_LOS, LALM_ACQ, LALM_SYNC} lalm_sync_t;
endpackage : lalm_pkg

//--- rtl/lalm_lane_sync.sv
/*
 one lane's character synchronisation machine with selectable error
 hysteresis and a least-spacing check on alignment characters.
 assumes lane character strobes come from logic on the same clock.
*/
`timescale 1ns/1ps
module lalm_lane_sync (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // lane characters
  input wire logic char_valid,
  input wire logic align_char,
  input wire logic code_err,
  // configuration
  input wire logic [1:0] hyst_sel,
  input wire logic [1:0] spacing_sel,
  input wire logic restart,
  // status
  output logic aligned
);
  lalm_pkg::lalm_sync_t st_q, st_d;
  logic [4:0] gap_q, gap_d;
  logic [1:0] cnt_q, cnt_d;
  logic [1:0] good_q, good_d;
  logic [4:0] min_gap;
  logic align_ok;

  always_comb begin
    case (spacing_sel)
      2'b00: min_gap = lalm_pkg::SPACE_8;
      2'b01: min_gap = lalm_pkg::SPACE_16;
      default: min_gap = lalm_pkg::SPACE_24;
    endcase
  end

  // alignment characters closer than the spacing are ignored
  assign align_ok = char_valid && align_char && !code_err && (gap_q >= min_gap);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    good_d = good_q;
    gap_d = gap_q;
    if (char_valid) begin
      if (align_ok) begin
        gap_d = 5'h01;
      end else if (gap_q < lalm_pkg::SPACE_24) begin
        gap_d = gap_q + 5'h01;
      end
    end
    case (st_q)
      lalm_pkg::LALM_LOS: begin
        if (align_ok) begin
          st_d = lalm_pkg::LALM_ACQ;
          cnt_d = 2'h1;
        end
      end
      lalm_pkg::LALM_ACQ: begin
        if (char_valid && code_err) begin
          st_d = lalm_pkg::LALM_LOS;
          cnt_d = 2'h0;
        end else if (align_ok) begin
          cnt_d = cnt_q + 2'h1;
          if (cnt_q + 2'h1 == lalm_pkg::ACQ_ALIGNS) begin
            st_d = lalm_pkg::LALM_SYNC;
            cnt_d = 2'h0;
            good_d = 2'h0;
          end
        end
      end
      lalm_pkg::LALM_SYNC: begin
        if (char_valid && code_err) begin
          good_d = 2'h0;
          if (hyst_sel == 2'b00) begin
            // standard hysteresis: fourth unrecovered error loses sync
            if (cnt_q == lalm_pkg::ERR_LVL_MAX) begin
              st_d = lalm_pkg::LALM_LOS;
              cnt_d = 2'h0;
            end else begin
              cnt_d = cnt_q + 2'h1;
            end
          end else if (cnt_q >= hyst_sel - 2'h1) begin
            st_d = lalm_pkg::LALM_LOS;
            cnt_d = 2'h0;
          end else begin
            cnt_d = cnt_q + 2'h1;
          end
        end else if (char_valid) begin
          if (hyst_sel != 2'b00) begin
            cnt_d = 2'h0;
          end else if (cnt_q != 2'h0) begin
            good_d = good_q + 2'h1;
            if (good_q == lalm_pkg::GOOD_RUN) begin
              cnt_d = cnt_q - 2'h1;
              good_d = 2'h0;
            end
          end
        end
      end
      default: st_d = lalm_pkg::LALM_LOS;
    endcase
    if (restart) begin
      st_d = lalm_pkg::LALM_LOS;
      cnt_d = 2'h0;
      good_d = 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= lalm_pkg::LALM_LOS;
      gap_q <= lalm_pkg::SPACE_24;
      cnt_q <= 2'h0;
      good_q <= 2'h0;
    end else begin
      st_q <= st_d;
      gap_q <= gap_d;
      cnt_q <= cnt_d;
      good_q <= good_d;
    end
  end

  assign aligned = (st_q == lalm_pkg::LALM_SYNC);

  a_fast_drop_one:
    assert property (@(posedge clk) disable iff (!nrst)
      (st_q == lalm_pkg::LALM_SYNC && hyst_sel == 2'b01 && char_valid && code_err && !restart)
      |=> st_q == lalm_pkg::LALM_LOS)
      else $error("single error did not drop sync");
  a_std_hyst_hold:
    assert property (@(posedge clk) disable iff (!nrst)
      (st_q == lalm_pkg::LALM_SYNC && hyst_sel == 2'b00 && cnt_q != lalm_pkg::ERR_LVL_MAX
       && !restart) |=> st_q == lalm_pkg::LALM_SYNC)
      else $error("standard hysteresis lost sync early");
  a_spacing_reject:
    assert property (@(posedge clk) disable iff (!nrst)
      (st_q == lalm_pkg::LALM_LOS && gap_q < min_gap && !restart) |=> st_q == lalm_pkg::LALM_LOS)
      else $error("close alignment character accepted");
endmodule : lalm_lane_sync

//--- rtl/lalm_link_monitor.sv
/*
 lane alignment slave link monitor: configuration and error-rate timer
 registers, four lane sync machines, lane status mirror, error-rate check
 and the latched-low link status flag.
 assumes: registers written on the management clock clk; loss-of-signal and
 pll lock arrive asynchronously; lane character strobes, the error-rate
 enable and the status read strobe come from logic on clk.
*/
// How it works
// - a two-bit selector picks which of four lanes drives the lane status output, lane 0 at reset.
// - selector 00 makes a synced lane leave sync only through the standard error hysteresis or a realign.
// - selector 01, 10, 11 drops sync at once after one, two or three adjacent errors.
// - alignment characters closer than 8, 16 or 24 characters are ignored, 24 at reset.
// - with the decode mask clear, decode errors of enabled lanes fail the link at or over threshold.
// - with the loss-of-signal mask clear, loss of signal on an enabled lane fails the link.
// - with the pll mask clear, loss of pll lock fails the link.
// - writing one to the realign bit restarts alignment on every lane.
// - the realign bit clears itself on the following clock.
// - at timer expiry the link is good only if errors are below 1, 15, 127 or 1023.
// - the error-rate period is a 16-bit register that resets to all ones.
// - threshold, timer and decode-error contribution act only while the rate check is enabled.
// - the configuration register resets to 0x03F0, its top two bits plain storage.
// - link ok rises on sync and alignment and stays low after a loss until status is read.
`timescale 1ns/1ps
module lalm_link_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // management registers
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // lane characters from the deserialisers
  input wire logic [3:0] lane_char_valid,
  input wire logic [3:0] lane_align_char,
  input wire logic [3:0] lane_code_err,
  input wire logic [3:0] lane_enable,
  // asynchronous analog status
  input wire logic [3:0] lane_los,
  input wire logic pll_lock,
  // channel control
  input wire logic ber_enable,
  input wire logic status_read,
  // status
  output logic lane_status,
  output logic ber_link_ok,
  output logic training_slave_link_ok
);
  logic [15:0] cfg_q, cfg_d, tmr_q, tmr_d, rdata_q, rdata_d;
  logic [15:0] cnt_q, cnt_d;
  logic [9:0] err_q, err_d, thr;
  logic ber_ok_q, ber_ok_d, lost_q, lost_d, ok_q, ok_d, lsel_q, lsel_d;
  logic [4:0] s1_q, s2_q, s3_q, filt_q, filt_d;
  logic [3:0] aligned;
  logic expire, ok_live, any_err, restart;

  // register file
  always_comb begin
    cfg_d = cfg_q;
    tmr_d = tmr_q;
    cfg_d[lalm_pkg::CFG_REALIGN] = 1'b0;
    if (reg_wr && reg_addr == lalm_pkg::ADDR_CFG) begin
      cfg_d = reg_wdata & lalm_pkg::CFG_WMASK;
    end
    if (reg_wr && reg_addr == lalm_pkg::ADDR_TMR) begin
      tmr_d = reg_wdata;
    end
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        lalm_pkg::ADDR_CFG: rdata_d = cfg_q;
        lalm_pkg::ADDR_TMR: rdata_d = tmr_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_q <= lalm_pkg::CFG_RST;
      tmr_q <= lalm_pkg::TMR_RST;
      rdata_q <= 16'h0000;
    end else begin
      cfg_q <= cfg_d;
      tmr_q <= tmr_d;
      rdata_q <= rdata_d;
    end
  end

  assign restart = cfg_q[lalm_pkg::CFG_REALIGN];

  // pin synchroniser, change taken when second and third stages agree
  always_comb begin
    filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      s3_q <= 5'h00;
      filt_q <= 5'h00;
    end else begin
      s1_q <= {pll_lock, lane_los};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  // lane sync machines
  genvar g;
  generate
    for (g = 0; g < lalm_pkg::NUM_LANES; g = g + 1) begin : g_lane
      lalm_lane_sync u_sync (
        .clk(clk),
        .nrst(nrst),
        .char_valid(lane_char_valid[g]),
        .align_char(lane_align_char[g]),
        .code_err(lane_code_err[g]),
        .hyst_sel(cfg_q[lalm_pkg::CFG_HYS_LSB +: 2]),
        .spacing_sel(cfg_q[lalm_pkg::CFG_SPACE_LSB +: 2]),
        .restart(restart),
        .aligned(aligned[g])
      );
    end
  endgenerate

  // error-rate check
  always_comb begin
    case (cfg_q[lalm_pkg::CFG_THR_LSB +: 2])
      2'b00: thr = lalm_pkg::THR_0;
      2'b01: thr = lalm_pkg::THR_1;
      2'b10: thr = lalm_pkg::THR_2;
      default: thr = lalm_pkg::THR_3;
    endcase
  end

  assign any_err = |(lane_code_err & lane_char_valid & lane_enable);
  assign expire = (cnt_q == 16'h0000);

  always_comb begin
    err_d = err_q;
    cnt_d = cnt_q;
    ber_ok_d = ber_ok_q;
    if (!ber_enable) begin
      err_d = 10'h000;
      cnt_d = tmr_q;
      ber_ok_d = 1'b1;
    end else if (expire) begin
      ber_ok_d = (err_q < thr);
      err_d = 10'h000;
      cnt_d = tmr_q;
    end else begin
      cnt_d = cnt_q - 16'h0001;
      if (any_err && err_q != lalm_pkg::ERR_CNT_MAX) begin
        err_d = err_q + 10'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      err_q <= 10'h000;
      cnt_q <= lalm_pkg::TMR_RST;
      ber_ok_q <= 1'b1;
    end else begin
      err_q <= err_d;
      cnt_q <= cnt_d;
      ber_ok_q <= ber_ok_d;
    end
  end

  // link status
  always_comb begin
    ok_live = &(aligned | ~lane_enable);
    if (!cfg_q[lalm_pkg::CFG_LOS_MASK] && |(filt_q[3:0] & lane_enable)) begin
      ok_live = 1'b0;
    end
    if (!cfg_q[lalm_pkg::CFG_PLL_MASK] && !filt_q[4]) begin
      ok_live = 1'b0;
    end
    if (!cfg_q[lalm_pkg::CFG_DEC_MASK] && ber_enable && !ber_ok_q) begin
      ok_live = 1'b0;
    end
    // loss is remembered until the status is read; a loss in the read cycle wins
    lost_d = lost_q;
    if (status_read) begin
      lost_d = 1'b0;
    end
    if (!ok_live) begin
      lost_d = 1'b1;
    end
    ok_d = ok_live && !lost_d;
    lsel_d = aligned[cfg_q[lalm_pkg::CFG_LSEL_LSB +: 2]];
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lost_q <= 1'b0;
      ok_q <= 1'b0;
      lsel_q <= 1'b0;
    end else begin
      lost_q <= lost_d;
      ok_q <= ok_d;
      lsel_q <= lsel_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign lane_status = lsel_q;
  assign ber_link_ok = ber_ok_q;
  assign training_slave_link_ok = ok_q;

  a_realign_selfclr:
    assert property (@(posedge clk) disable iff (!nrst)
      cfg_q[lalm_pkg::CFG_REALIGN] && !reg_wr |=> !cfg_q[lalm_pkg::CFG_REALIGN])
      else $error("realign bit did not self clear");
  a_cfg_reset:
    assert property (@(posedge clk) !nrst |=> cfg_q == 16'h03F0 && tmr_q == 16'hFFFF)
      else $error("register reset value wrong");
  a_lane_mirror:
    assert property (@(posedge clk) disable iff (!nrst)
      ##1 lane_status == $past(aligned[cfg_q[13:12]]))
      else $error("lane status not mirrored");
  a_expiry_judge:
    assert property (@(posedge clk) disable iff (!nrst)
      ber_enable && expire |=> ber_link_ok == ($past(err_q) < $past(thr)) && err_q == 10'h000)
      else $error("error rate judged wrongly");
  a_timer_reload:
    assert property (@(posedge clk) disable iff (!nrst)
      ber_enable && expire |=> cnt_q == $past(tmr_q))
      else $error("timer not reloaded");
  a_ber_disabled:
    assert property (@(posedge clk) disable iff (!nrst) !ber_enable |=> ber_link_ok)
      else $error("rate check acted while disabled");
  a_pll_unmasked:
    assert property (@(posedge clk) disable iff (!nrst)
      !cfg_q[4] && !filt_q[4] |=> !training_slave_link_ok)
      else $error("pll loss ignored");
  a_los_unmasked:
    assert property (@(posedge clk) disable iff (!nrst)
      !cfg_q[5] && |(filt_q[3:0] & lane_enable) |=> !training_slave_link_ok)
      else $error("signal loss ignored");
  a_latch_low:
    assert property (@(posedge clk) disable iff (!nrst)
      !ok_live ##1 !status_read |=> !training_slave_link_ok)
      else $error("link ok rose without a status read");
  a_realign_drops:
    assert property (@(posedge clk) disable iff (!nrst) restart |=> aligned == 4'h0)
      else $error("realign did not restart lanes");

  c_link_up: cover property (@(posedge clk) disable iff (!nrst) $rose(training_slave_link_ok));
  c_ber_fail: cover property (@(posedge clk) disable iff (!nrst) $fell(ber_link_ok));
  c_realign: cover property (@(posedge clk) disable iff (!nrst) restart ##1 aligned == 4'h0);
endmodule : lalm_link_monitor

//--- tb/lalm_lane_host.sv
/*
 lane host model: one character per cycle on all four lanes on request.
 assumes the bench changes requests just after rising clk edges.
*/
`timescale 1ns/1ps
module lalm_lane_host (
  // requests
  input wire logic send,
  input wire logic [3:0] al,
  input wire logic [3:0] er,
  input wire logic [7:0] noise,
  // lanes
  output logic [3:0] lane_char_valid,
  output logic [3:0] lane_align_char,
  output logic [3:0] lane_code_err
);
  // unqualified lines carry noise, not the last value
  assign lane_char_valid = {4{send}};
  assign lane_align_char = send ? al : noise[3:0];
  assign lane_code_err = send ? er : noise[7:4];
endmodule : lalm_lane_host

//--- tb/lalm_link_monitor_tb_top.sv
/*
 self-checking bench for the link monitor with a lane host model.
 assumes the monitor samples everything on clk, reset low and synchronous.
*/
`timescale 1ns/1ps
module lalm_link_monitor_tb_top;
  logic clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, pll_lock = 1, ber_enable = 0;
  logic status_read = 0, send = 0, lane_status, ber_link_ok, tslo;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv;
  logic [3:0] lane_enable = 4'hf, lane_los = 4'h0, al = 4'h0, er = 4'h0, lcv, lac, lce;
  logic [31:0] lfsr_q = 32'h0000_f16c;
  int miscompares = 0, check_count = 0, exp_cfg = 0, cyc = 0;
  // cycle stamps of the error characters sent in one error-rate period
  int errq[$];

  always #2.5 clk = ~clk;

  function automatic logic [31:0] lfsr_next(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next

  always @(posedge clk) begin
    lfsr_q <= lfsr_next(lfsr_q);
    cyc <= cyc + 1;
  end

  lalm_link_monitor lalm_link_monitor_inst (.clk(clk), .nrst(nrst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .lane_char_valid(lcv), .lane_align_char(lac), .lane_code_err(lce),
    .lane_enable(lane_enable), .lane_los(lane_los), .pll_lock(pll_lock),
    .ber_enable(ber_enable), .status_read(status_read), .lane_status(lane_status),
    .ber_link_ok(ber_link_ok), .training_slave_link_ok(tslo));

  lalm_lane_host lalm_lane_host_inst (.send(send), .al(al), .er(er), .noise(lfsr_q[7:0]),
    .lane_char_valid(lcv), .lane_align_char(lac), .lane_code_err(lce));

  // model of the documented figures
  function automatic int min_sp(int c);
    return c == 0 ? 8 : c == 1 ? 16 : 24;
  endfunction : min_sp

  function automatic int thr(int c);
    return c == 0 ? 1 : c == 1 ? 15 : c == 2 ? 127 : 1023;
  endfunction : thr

  task end_sim;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task chk(string n, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task clks(int n);
    repeat (n) @(posedge clk);
  endtask : clks

  task wr(logic [4:0] a, logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
  endtask : wr

  task rd(logic [4:0] a);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 rv = reg_rdata;
  endtask : rd

  task cfg(logic [15:0] v);
    wr(lalm_pkg::ADDR_CFG, v);
    exp_cfg = v & lalm_pkg::CFG_WMASK & 16'hfffb;
  endtask : cfg

  task chars(logic [3:0] a, logic [3:0] e, int n);
    repeat (n) begin
      @(posedge clk);
      send <= 1;
      al <= a;
      er <= e;
    end
    @(posedge clk);
    send <= 0;
  endtask : chars

  // three alignment characters k characters apart
  task train(int k);
    clks(2);
    repeat (3) begin
      chars(4'hf, 4'h0, 1);
      chars(4'h0, 4'h0, k - 1);
    end
    chars(4'h0, 4'h0, 8);
    clks(3);
  endtask : train

  task rsr;
    @(posedge clk);
    status_read <= 1;
    @(posedge clk);
    status_read <= 0;
    clks(2);
  endtask : rsr

  task link(logic [15:0] c, logic [3:0] l, logic p, logic e);
    cfg(c);
    clks(1);
    lane_los <= l;
    pll_lock <= p;
    clks(6);
    rsr();
    chk("link_ok", e, tslo);
  endtask : link

  initial begin
    int t0;
    int tt;
    clks(5);
    nrst <= 1;
    clks(1);
    rd(lalm_pkg::ADDR_CFG);
    chk("cfg_reset", 16'h03f0, rv);
    rd(lalm_pkg::ADDR_TMR);
    chk("tmr_reset", 16'hffff, rv);
    rd(5'h1f);
    chk("unmapped", 16'h0000, rv);
    chk("ber_off_reset", 1, ber_link_ok);
    cfg(16'hc3f8);
    rd(lalm_pkg::ADDR_CFG);
    chk("cfg_rw", exp_cfg, rv);
    wr(lalm_pkg::ADDR_TMR, 16'ha5c3);
    rd(lalm_pkg::ADDR_TMR);
    chk("tmr_rw", 16'ha5c3, rv);
    for (int c = 0; c < 4; c++) begin
      for (int d = -2; d <= 2; d += 4) begin
        cfg(16'h00f4 | (c << 8));
        train(min_sp(c) + d);
        chk("sync_space", d > 0, lane_status);
      end
    end
    rsr();
    chk("link_up", 1, tslo);
    // read issued right behind the write, in the one cycle the realign bit stands
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= lalm_pkg::ADDR_CFG;
    reg_wdata <= 16'h03f4;
    @(posedge clk);
    reg_wr <= 0;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1 rv = reg_rdata;
    chk("realign_set", 16'h03f4, rv);
    rd(lalm_pkg::ADDR_CFG);
    chk("realign_clr", 16'h03f0, rv);
    chk("realign_lane", 0, lane_status);
    for (int h = 0; h < 4; h++) begin
      cfg(16'h00f4 | (h << 10));
      train(10);
      chars(4'h0, 4'h1, h == 0 ? 3 : h - 1);
      clks(3);
      chk("hys_hold", 1, lane_status);
      chars(4'h0, 4'h1, 1);
      clks(3);
      chk("hys_drop", 0, lane_status);
    end
    chk("link_lost", 0, tslo);
    for (int s = 0; s < 4; s++) begin
      cfg(16'h0cf0 | (s << 12));
      clks(3);
      chk("lane_sel", s != 0, lane_status);
    end
    clks(1);
    lane_enable <= 4'he;
    rsr();
    chk("link_release", 1, tslo);
    lane_enable <= 4'hf;
    clks(3);
    lane_enable <= 4'he;
    clks(3);
    chk("link_latched", 0, tslo);
    link(16'h0cf0, 4'h2, 0, 1);
    link(16'h0cd0, 4'h2, 1, 0);
    link(16'h0cd0, 4'h1, 1, 1);
    link(16'h0ce0, 4'h0, 0, 0);
    link(16'h0070, 4'h0, 1, 1);
    chars(4'h0, 4'h2, 1);
    clks(3);
    chk("ber_off", 1, ber_link_ok);
    for (int c = 0; c < 4; c++) begin
      for (int e = thr(c) - 1; e <= thr(c); e++) begin
        tt = 7 * e + 40;
        cfg(16'h0070 | c);
        wr(lalm_pkg::ADDR_TMR, tt);
        clks(1);
        ber_enable <= 1;
        t0 = cyc;
        errq.delete();
        repeat (e) begin
          errq.push_back(cyc);
          chars(4'h0, 4'h2, 1);
          chars(4'h0, 4'h0, 4);
        end
        clks(tt + 5 - (cyc - t0));
        chk("ber_judge", errq.size() < thr(c), ber_link_ok);
        rsr();
        chk("ber_link", errq.size() < thr(c), tslo);
        clks(tt + 1);
        chk("ber_next", 1, ber_link_ok);
        clks(1);
        ber_enable <= 0;
      end
    end
    end_sim();
  end

  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule : lalm_link_monitor_tb_top
